// [dv/bsft_host.sv]
// bus master model that drives the burst memory from the controller side
`timescale 1ns/1ps
module bsft_host (
  // clock
  input wire logic sys_clk,
  // strobes {processor, controller, advance}, selects {primary_n, high, low_n}
  output logic [2:0] strb,
  output logic [2:0] sel,
  // writes {global_n, qualifier_n, lanes_n}, address and data
  output logic [5:0] wr,
  output logic [14:0] addr,
  output logic [35:0] wdat,
  output logic oeN
);
  logic lastWr = 1'b0;
  initial begin
    {strb, sel, wr} = 12'hFBF;
    addr = 15'h0000;
    wdat = 36'h0;
    oeN = 1'b1;
  end
  //==============================================================
  // one bus cycle, driven just after the falling edge
  task automatic cyc(logic [2:0] s, logic [2:0] c, logic [5:0] w, logic [14:0] a, logic [35:0] d);
    logic isW;
    @(negedge sys_clk);
    // a processor start with the primary select low always reads
    isW = (s[2] || c[2]) && (!w[5] || (!w[4] && w[3:0] != 4'hF));
    {strb, sel, wr} = {s, c, w};
    addr = a;
    oeN = isW | lastWr;
    lastWr = isW;
    // released lanes toggle so stale data never looks valid
    wdat = isW ? d : ~wdat;
  endtask
endmodule

// [dv/tb_burst_sram_flow_through_control.sv]
// self-checking bench for the flow-through burst memory
`timescale 1ns/1ps
module tb_burst_sram_flow_through_control;
  localparam logic [14:0] A = 15'h1234;
  localparam logic [14:0] B = 15'h0240;
  localparam logic [14:0] C = 15'h0500;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic order = 1'b0;
  logic [2:0] strb, sel;
  logic [5:0] wr;
  logic [14:0] addr;
  logic [35:0] wdat, rdat;
  logic oeN, oe;
  int n_fail = 0;
  int checks = 0;
  int ticks = 0;
  bsft_host HOST (.sys_clk(sys_clk), .strb(strb), .sel(sel), .wr(wr), .addr(addr),
    .wdat(wdat), .oeN(oeN));
  bsft_sram DUT (.sys_clk(sys_clk), .srst(srst), .addressInputs(addr),
    .processorStartStrobe_n(strb[2]), .controllerStartStrobe_n(strb[1]),
    .burstAdvance_n(strb[0]), .burstOrderSelect(order), .primaryChipSelect_n(sel[2]),
    .depthSelectHigh(sel[1]), .depthSelectLow_n(sel[0]), .byteWriteStrobes_n(wr[3:0]),
    .globalWriteStrobe_n(wr[5]), .writeQualifier_n(wr[4]), .byteLaneDataIn(wdat),
    .byteLaneDataOut(rdat), .byteLaneDataOe(oe), .outputDriveEnable_n(oeN));
  //==============================================================
  // clock and hang guard, sized far above the real run
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ticks++;
    if (ticks > 3000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // sample two ns after the edge so flow-through data has settled
  task automatic look(logic [35:0] e, logic eo);
    @(posedge sys_clk);
    #2;
    chk("rdat", e, rdat);
    chk("oe", {35'h0, eo}, {35'h0, oe});
  endtask
  task automatic wr_at(logic [14:0] a, logic [5:0] w, logic [35:0] d);
    HOST.cyc(3'b101, 3'h2, w, a, d);
    @(posedge sys_clk);
    #2;
    chk("oe", 36'h0, {35'h0, oe});
    HOST.cyc(3'h7, 3'h2, 6'h3F, a, d);
  endtask
  task automatic rdck(logic [14:0] a, logic [35:0] e);
    HOST.cyc(3'b011, 3'h2, 6'h3F, a, 36'h0);
    look(e, 1'b1);
  endtask
  //==============================================================
  // writes: global, single lane, unqualified, processor start
  task automatic s_write();
    wr_at(A, 6'h1F, 36'h987654321);
    rdck(A, 36'h987654321);
    wr_at(A, 6'h2D, 36'h0);
    rdck(A, 36'h987640121);
    HOST.cyc(3'b101, 3'h2, 6'h3D, A, 36'h5);
    look(36'h987640121, 1'b1);
    // qualifier with no lane strobe stays a read
    HOST.cyc(3'b101, 3'h2, 6'h2F, A, 36'h5);
    look(36'h987640121, 1'b1);
    HOST.cyc(3'b011, 3'h2, 6'h1F, A, 36'h5);
    rdck(A, 36'h987640121);
    // continued write lands on the next burst address
    wr_at(C, 6'h1F, 36'h111);
    HOST.cyc(3'b110, 3'h2, 6'h1F, C, 36'h222);
    HOST.cyc(3'h7, 3'h2, 6'h3F, C, 36'h0);
    rdck(C + 15'h0001, 36'h222);
    rdck(C, 36'h111);
  endtask
  // bursts in both orders, wrap and suspend
  task automatic s_burst();
    logic [1:0] e;
    for (int o = 0; o < 2; o++) begin
      @(negedge sys_clk);
      srst = 1'b1;
      order = o[0];
      @(negedge sys_clk);
      srst = 1'b0;
      for (int i = 0; i < 4; i++) wr_at(B + 15'(i), 6'h1F, 36'hA00 + 36'(i));
      for (int s = 1; s < 3; s++) begin
        rdck(B + 15'(s), 36'hA00 + 36'(s));
        for (int k = 1; k < 6; k++) begin
          e = o[0] ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0]);
          HOST.cyc(3'b110, 3'h2, 6'h3F, A, 36'h0);
          look(36'hA00 + 36'(e), 1'b1);
        end
        HOST.cyc(3'h7, 3'h2, 6'h3F, A, 36'h0);
        look(36'hA00 + 36'(e), 1'b1);
      end
    end
  endtask
  // ignored strobe, three deselects, asynchronous enable
  task automatic s_select();
    rdck(A, 36'h987640121);
    HOST.cyc(3'b011, 3'b110, 6'h3F, B, 36'h0);
    look(36'h987640121, 1'b1);
    #3 HOST.oeN = 1'b1;
    #1 chk("oe", 36'h0, {35'h0, oe});
    HOST.oeN = 1'b0;
    #1 chk("oe", 36'h1, {35'h0, oe});
    HOST.cyc(3'b101, 3'b110, 6'h3F, A, 36'h0);
    look(36'h0, 1'b0);
    rdck(A, 36'h987640121);
    HOST.cyc(3'b011, 3'b000, 6'h3F, A, 36'h0);
    look(36'h0, 1'b0);
    rdck(A, 36'h987640121);
    HOST.cyc(3'b101, 3'b011, 6'h3F, A, 36'h0);
    look(36'h0, 1'b0);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    s_write();
    s_burst();
    s_select();
    close_out();
  end
endmodule

// [hdl/bsft_pkg.sv]
// constants shared by the flow-through burst memory
package bsft_pkg;
  localparam int ADDR_W = 15;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
endpackage

// [hdl/bsft_sram.sv]
// flow-through synchronous burst static memory, 32K words of 36 bits
//==============================================================
// Overview of operation
// - 32K words, four lanes, per-lane byte strobes
// - all inputs registered except drive enable, order
// - order low: low bits increment modulo four
// - order high: low bits interleave by xor
// - external start needs all three selects active
// - three deselect cases float the lanes
// - processor strobe ignored while primary select high
// - processor strobe start always reads
// - no start: advance steps, else holds address
// - write when qualifier plus byte strobe, or global
// - qualified write updates only strobed lanes
// - global write updates all four lanes
// - write timed internally from the clock edge
// - lanes driven only on read with enable low
// - drive enable acts without clock sampling
// - read data flows from array unregistered
`timescale 1ns/1ps
module bsft_sram #(
  parameter int ADDR_W = bsft_pkg::ADDR_W,
  parameter int LANES = bsft_pkg::LANES,
  parameter int LANE_W = bsft_pkg::LANE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // address and burst control
  input wire logic [ADDR_W-1:0] addressInputs,
  input wire logic processorStartStrobe_n,
  input wire logic controllerStartStrobe_n,
  input wire logic burstAdvance_n,
  input wire logic burstOrderSelect,
  // chip selects
  input wire logic primaryChipSelect_n,
  input wire logic depthSelectHigh,
  input wire logic depthSelectLow_n,
  // write strobes
  input wire logic [LANES-1:0] byteWriteStrobes_n,
  input wire logic globalWriteStrobe_n,
  input wire logic writeQualifier_n,
  // byte lanes, split three ways
  input wire logic [LANES*LANE_W-1:0] byteLaneDataIn,
  output logic [LANES*LANE_W-1:0] byteLaneDataOut,
  output logic byteLaneDataOe,
  input wire logic outputDriveEnable_n
);
  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  //==============================================================
  // state
  typedef struct packed {
    logic [ADDR_W-1:0] baseAddr;
    logic [bsft_pkg::BURST_W-1:0] startLow;
    logic [bsft_pkg::BURST_W-1:0] count;
    logic selected;
    logic isWrite;
    logic wrPending;
    logic [LANES-1:0] wrLanes;
    logic [WORD_W-1:0] wrData;
  } bsft_state_t;

  bsft_state_t state;
  bsft_state_t next_state;
  // one word per address, four lanes
  logic [WORD_W-1:0] memArray [DEPTH];

  // decoded request of this edge
  logic allSelected;
  logic procStart;
  logic ctrlStart;
  logic extStart;
  logic deselect;
  logic writeReq;
  logic [LANES-1:0] laneMask;
  logic [bsft_pkg::BURST_W-1:0] burstLow;
  logic [ADDR_W-1:0] curAddr;

  //==============================================================
  // request decode
  // external start qualifiers
  assign allSelected = !primaryChipSelect_n && depthSelectHigh && !depthSelectLow_n;
  assign procStart = !processorStartStrobe_n && !primaryChipSelect_n;
  assign ctrlStart = !controllerStartStrobe_n && processorStartStrobe_n;
  assign extStart = allSelected && (procStart || ctrlStart);
  assign deselect = (!controllerStartStrobe_n && primaryChipSelect_n)
    || (procStart && !allSelected)
    || (!controllerStartStrobe_n && !allSelected);
  assign writeReq = !globalWriteStrobe_n
    || (!writeQualifier_n && (byteWriteStrobes_n != '1));
  assign laneMask = !globalWriteStrobe_n ? '1
    : (!writeQualifier_n ? ~byteWriteStrobes_n : '0);

  assign burstLow = burstOrderSelect ? (state.startLow ^ state.count)
    : bsft_pkg::BURST_W'(state.startLow + state.count);
  assign curAddr = {state.baseAddr[ADDR_W-1:bsft_pkg::BURST_W], burstLow};

  //==============================================================
  // next state
  always_comb begin
    next_state = state;
    next_state.wrPending = 1'b0;
    if (srst) begin
      next_state = '0;
    end else if (extStart) begin
      next_state.baseAddr = addressInputs;
      next_state.startLow = addressInputs[bsft_pkg::BURST_W-1:0];
      next_state.count = bsft_pkg::BURST_ZERO;
      next_state.selected = 1'b1;
      next_state.isWrite = procStart ? 1'b0 : writeReq;
      next_state.wrPending = !procStart && writeReq;
    end else if (deselect) begin
      next_state.selected = 1'b0;
      next_state.isWrite = 1'b0;
    end else if (state.selected) begin
      if (!burstAdvance_n) begin
        next_state.count = bsft_pkg::BURST_W'(state.count + bsft_pkg::BURST_STEP);
      end
      next_state.isWrite = writeReq;
      next_state.wrPending = writeReq;
    end
    next_state.wrLanes = laneMask;
    next_state.wrData = byteLaneDataIn;
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  //==============================================================
  // array write, one cycle after the capturing edge
  // internal write timing from registered request
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (state.wrPending && state.wrLanes[i]) begin
        memArray[curAddr][i*LANE_W +: LANE_W] <= state.wrData[i*LANE_W +: LANE_W];
      end
    end
  end

  //==============================================================
  // read path, no output register
  // flow-through read
  assign byteLaneDataOut = state.selected ? memArray[curAddr] : '0;
  // drive on read only; enable unsampled
  assign byteLaneDataOe = state.selected && !state.isWrite && !outputDriveEnable_n;

  //==============================================================
  // checks
  // steps of a transfer, shared by the properties below
  sequence ctrlWriteStart_s;
    allSelected && ctrlStart && writeReq && !srst;
  endsequence

  sequence advanceStep_s;
    state.selected && !extStart && !deselect && !burstAdvance_n;
  endsequence

  sequence interleaveStep_s;
    burstOrderSelect && state.selected && !extStart && !deselect && !burstAdvance_n;
  endsequence

  sequence procReadStart_s;
    allSelected && !processorStartStrobe_n;
  endsequence

  deselect_floats_a: assert property (@(posedge sys_clk) disable iff (srst)
    (deselect && !extStart) |=> !byteLaneDataOe)
    else $error("lanes driven after deselect");

  proc_reads_a: assert property (@(posedge sys_clk) disable iff (srst)
    (extStart && procStart) |=> !state.isWrite)
    else $error("processor start did not read");

  ext_start_a: assert property (@(posedge sys_clk) disable iff (srst)
    extStart |=> (state.selected && curAddr == $past(addressInputs)))
    else $error("external address not loaded");

  proc_blocked_a: assert property (@(posedge sys_clk) disable iff (srst)
    (primaryChipSelect_n && controllerStartStrobe_n && state.selected)
      |=> state.selected)
    else $error("processor strobe acted while unselected");

  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    ctrlWriteStart_s |=> (state.isWrite && state.wrPending))
    else $error("controller write not begun");

  global_lanes_a: assert property (@(posedge sys_clk) disable iff (srst)
    !globalWriteStrobe_n |=> (state.wrLanes == '1))
    else $error("global write missed a lane");

  hold_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state.selected && !extStart && !deselect && burstAdvance_n)
      |=> $stable(curAddr))
    else $error("address moved without advance");

  burst_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state.selected && !extStart && !deselect && !burstAdvance_n) [*4]
      |=> (burstLow == $past(burstLow, 4)))
    else $error("burst did not wrap after four");

  linear_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!burstOrderSelect && state.selected && !extStart && !deselect && !burstAdvance_n)
      |=> (burstLow == bsft_pkg::BURST_W'($past(burstLow) + bsft_pkg::BURST_STEP)))
    else $error("linear step wrong");

  write_oe_a: assert property (@(posedge sys_clk) disable iff (srst)
    ctrlWriteStart_s |=> !byteLaneDataOe)
    else $error("lanes driven during write");

  interleave_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    interleaveStep_s |=> ((burstLow ^ state.startLow)
      == bsft_pkg::BURST_W'($past(burstLow ^ state.startLow) + bsft_pkg::BURST_STEP)))
    else $error("interleaved step wrong");

  advance_moves_a: assert property (@(posedge sys_clk) disable iff (srst)
    advanceStep_s |=> $changed(burstLow))
    else $error("advance left the address");

  start_base_a: assert property (@(posedge sys_clk) disable iff (srst)
    extStart |=> (burstLow == $past(addressInputs[bsft_pkg::BURST_W-1:0])))
    else $error("burst did not start at base");

  select_needed_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!allSelected && !state.selected) |=> !state.selected)
    else $error("started without all selects");

  ctrl_desel_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!controllerStartStrobe_n && primaryChipSelect_n) |=> !state.selected)
    else $error("controller strobe kept chip selected");

  proc_desel_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!processorStartStrobe_n && !primaryChipSelect_n
      && !(depthSelectHigh && !depthSelectLow_n)) |=> !state.selected)
    else $error("processor strobe kept chip selected");

  depth_desel_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!controllerStartStrobe_n && !(depthSelectHigh && !depthSelectLow_n))
      |=> !state.selected)
    else $error("depth select did not deselect");

  proc_ignored_a: assert property (@(posedge sys_clk) disable iff (srst)
    (primaryChipSelect_n && controllerStartStrobe_n && !processorStartStrobe_n)
      |=> $stable(state.baseAddr))
    else $error("ignored strobe loaded an address");

  proc_no_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    procReadStart_s |=> (state.selected && !state.wrPending))
    else $error("processor start wrote");

  unqualified_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (allSelected && ctrlStart && globalWriteStrobe_n
      && (writeQualifier_n || (&byteWriteStrobes_n))) |=> !state.isWrite)
    else $error("read cycle taken as write");

  lane_mask_a: assert property (@(posedge sys_clk) disable iff (srst)
    (globalWriteStrobe_n && !writeQualifier_n)
      |=> (state.wrLanes == ~$past(byteWriteStrobes_n)))
    else $error("lane mask does not follow strobes");

  no_lanes_a: assert property (@(posedge sys_clk) disable iff (srst)
    (globalWriteStrobe_n && writeQualifier_n) |=> (state.wrLanes == '0))
    else $error("lanes armed without write");

  oe_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    outputDriveEnable_n |-> !byteLaneDataOe)
    else $error("lanes driven with enable high");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    !state.selected |-> (!byteLaneDataOe && byteLaneDataOut == '0))
    else $error("deselected chip drives data");

  commit_once_a: assert property (@(posedge sys_clk) disable iff (srst)
    state.wrPending |=> (!state.wrPending || $past(writeReq)))
    else $error("write armed without request");

endmodule
